/* File: inc/scu_pkg.sv */
package scu_pkg;
  // device register addresses on the link
  localparam logic [19:0] SCU_ADDR_STATUS = 20'hf_0100;
  localparam logic [19:0] SCU_ADDR_FLAG_CLR = 20'hf_0108;
  localparam logic [19:0] SCU_ADDR_MODE = 20'hf_0110;
  localparam logic [19:0] SCU_ADDR_COMM = 20'hf_0118;
  localparam logic [19:0] SCU_ADDR_START = 20'hf_0122;
  localparam logic [19:0] SCU_ADDR_STOP = 20'hf_0124;
  localparam logic [19:0] SCU_ADDR_DATA = 20'hf_ff10;
  // reset values
  localparam logic [15:0] SCU_COMM_RST = 16'h0087;
  localparam logic [15:0] SCU_MODE_RST = 16'h0020;
  localparam logic [15:0] SCU_DATA_RST = 16'h0000;
  // comm_setting_reg fields
  localparam int SCU_TXE = 15;
  localparam int SCU_RXE = 14;
  localparam int SCU_RSV11 = 11;
  localparam int SCU_EOC = 10;
  localparam int SCU_PTC_LO = 8;
  localparam int SCU_DIR = 7;
  localparam int SCU_RSV6 = 6;
  localparam int SCU_SLC_LO = 4;
  localparam int SCU_RSV3 = 3;
  localparam int SCU_ONE2 = 2;
  localparam int SCU_DLS_HI = 1;
  localparam int SCU_DLS_LO = 0;
  // channel_mode_reg fields
  localparam int SCU_CCS = 14;
  localparam int SCU_MD_LO = 1;
  localparam int SCU_MD_IRQ = 0;
  // data_divider_reg divider field
  localparam int SCU_DIV_LO = 9;
  // flag bits in flag_clear_reg and status
  localparam int SCU_FE = 2;
  localparam int SCU_PE = 1;
  localparam int SCU_OV = 0;
  localparam int SCU_BFF = 5;
  localparam int SCU_TSF = 6;
  localparam int SCU_SE = 7;
  // controller registers on AXI4-Lite
  localparam logic [7:0] SCU_AXI_ADDR = 8'h00;
  localparam logic [7:0] SCU_AXI_WDATA = 8'h04;
  localparam logic [7:0] SCU_AXI_GO = 8'h08;
  localparam logic [7:0] SCU_AXI_RDATA = 8'h0c;
  localparam logic [7:0] SCU_AXI_STAT = 8'h10;
  localparam int SCU_CMD_BYTE = 24;
  localparam logic [1:0] SCU_RESP_OKAY = 2'b00;
  localparam logic [1:0] SCU_RESP_SLVERR = 2'b10;
  // operation modes
  typedef enum logic [1:0] {
    SCU_MODE_CSI = 2'b00,
    SCU_MODE_UART = 2'b01,
    SCU_MODE_SIMPLE = 2'b10
  } scu_mode_type;
endpackage

/* File: inc/scu_link_if.sv */
`timescale 1ns/1ps
interface scu_link_if (
  input logic sys_clk,
  input logic rst
);
  logic req;
  logic wr;
  logic byte_wr;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  logic chan_enabled;
  // documented channel end
  modport dev (input req, wr, byte_wr, addr, wdata, output rdata, ack, chan_enabled);
  // controller end
  modport ctl (output req, wr, byte_wr, addr, wdata, input rdata, ack, chan_enabled);
endinterface

/* File: core/scu_dev.sv */
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module scu_dev
  import scu_pkg::*;
#(
  parameter int BUF_BITS = 9,
  parameter bit HAS_SLC_HI = 1'b1,
  parameter bit HAS_DLS_HI = 1'b1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register link
  scu_link_if.dev link,
  // serial line
  input wire logic rxd,
  input wire logic serial_clock_pin,
  output logic txd,
  output logic sck_out,
  // interrupt pulses
  output logic chan_irq,
  output logic receive_interrupt,
  output logic error_interrupt
);
  typedef enum logic [4:0] {
    SCU_IDLE = 5'b00001,
    SCU_START = 5'b00010,
    SCU_DATA = 5'b00100,
    SCU_PAR = 5'b01000,
    SCU_STOP = 5'b10000
  } scu_bit_type;
  localparam logic [8:0] BUF_MASK = (BUF_BITS == 9) ? 9'h1ff : 9'h0ff;
  logic [15:0] comm_q, mode_q, data_q, rdata_q;
  logic se_q, bff_q, fef_q, pef_q, ovf_q, ack_q;
  scu_bit_type tx_q, rx_q;
  logic [8:0] tx_sh_q, rx_sh_q;
  logic [3:0] tx_idx_q, rx_idx_q;
  logic [1:0] stop_idx_q;
  logic [6:0] tick_cnt_q;
  logic [7:0] rx_cnt_q;
  logic phase_q, sck_prev_q, rxd_prev_q, rx_perr_q;
  logic txd_q, sck_q, chan_irq_q, rcv_irq_q, err_irq_q;
  // decoded settings
  logic txe, rxe, eoc, dir, ccs, md_irq;
  logic [1:0] ptc, slc, nstop;
  logic [6:0] div;
  logic [3:0] nbits;
  logic [8:0] dmask;
  scu_mode_type md;
  logic wr_comm, wr_mode, wr_data, rd_data, wr_clr, wr_start, wr_stop;
  logic bit_tick, half, tx_load, tx_end, rx_done, rx_fe, rx_ovr;
  assign txe = comm_q[SCU_TXE];
  assign rxe = comm_q[SCU_RXE];
  assign eoc = comm_q[SCU_EOC];
  assign ptc = comm_q[SCU_PTC_LO+1:SCU_PTC_LO];
  assign dir = comm_q[SCU_DIR];
  assign slc = comm_q[SCU_SLC_LO+1:SCU_SLC_LO];
  assign div = data_q[15:SCU_DIV_LO];
  assign ccs = mode_q[SCU_CCS];
  assign md_irq = mode_q[SCU_MD_IRQ];
  assign md = scu_mode_type'(mode_q[SCU_MD_LO+1:SCU_MD_LO]);
  // link request decode
  assign wr_comm = link.req & link.wr & (link.addr == SCU_ADDR_COMM);
  assign wr_mode = link.req & link.wr & (link.addr == SCU_ADDR_MODE);
  assign wr_data = link.req & link.wr & (link.addr == SCU_ADDR_DATA);
  assign rd_data = link.req & ~link.wr & (link.addr == SCU_ADDR_DATA);
  assign wr_clr = link.req & link.wr & (link.addr == SCU_ADDR_FLAG_CLR);
  assign wr_start = link.req & link.wr & (link.addr == SCU_ADDR_START) & link.wdata[0];
  assign wr_stop = link.req & link.wr & (link.addr == SCU_ADDR_STOP) & link.wdata[0];
  // frame length and stop count
  always_comb
  begin
    unique case (comm_q[SCU_DLS_HI:SCU_DLS_LO])
      2'b01: nbits = 4'd9;
      2'b10: nbits = 4'd7;
      default: nbits = 4'd8;
    endcase
    unique case (slc)
      2'b00: nstop = 2'd0;
      2'b10: nstop = HAS_SLC_HI ? 2'd2 : 2'd1;
      default: nstop = 2'd1;
    endcase
    dmask = 9'(9'h1ff >> (4'd9 - nbits)) & BUF_MASK;
  end
  // transfer clock: internal divider or external pin edge
  assign half = (tick_cnt_q == div);
  assign bit_tick = ccs ? (serial_clock_pin & ~sck_prev_q) : (half & phase_q);
  assign tx_load = (tx_q == SCU_IDLE) & se_q & txe & bff_q;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_q <= 7'h00;
      phase_q <= 1'b0;
      sck_prev_q <= 1'b1; // pin idles high, no false edge after reset
    end
    else
    begin
      sck_prev_q <= serial_clock_pin;
      if (tx_q == SCU_IDLE || half)
        tick_cnt_q <= 7'h00;
      else
        tick_cnt_q <= tick_cnt_q + 7'h01;
      if (tx_q == SCU_IDLE)
        phase_q <= 1'b0;
      else if (half)
        phase_q <= ~phase_q;
    end
  end
  // register file writes
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      comm_q <= SCU_COMM_RST;
      mode_q <= SCU_MODE_RST;
      se_q <= 1'b0;
    end
    else
    begin
      if (wr_comm)
        comm_q <= HAS_DLS_HI ? link.wdata : (link.wdata | 16'h0002);
      if (wr_mode)
        mode_q <= link.wdata;
      if (wr_start)
        se_q <= 1'b1;
      else if (wr_stop)
        se_q <= 1'b0;
    end
  end
  // data buffer and divider
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      data_q <= SCU_DATA_RST;
    else if (wr_data && se_q)
      data_q[8:0] <= link.wdata[8:0] & BUF_MASK;
    else if (wr_data && link.byte_wr)
      data_q <= {8'h00, link.wdata[7:0]};
    else if (wr_data)
      data_q <= {link.wdata[15:9], link.wdata[8:0] & BUF_MASK};
    else if (rx_done && rxe)
      data_q[8:0] <= rx_sh_q & dmask;
  end
  // buffer and error flags, set wins over clear
  assign rx_fe = ~rxd;
  assign rx_ovr = rx_done & bff_q;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bff_q <= 1'b0;
      fef_q <= 1'b0;
      pef_q <= 1'b0;
      ovf_q <= 1'b0;
    end
    else
    begin
      if ((wr_data && se_q && txe) || (rx_done && rxe))
        bff_q <= 1'b1;
      else if (tx_load || rd_data || wr_stop)
        bff_q <= 1'b0;
      if (rx_done && rx_fe)
        fef_q <= 1'b1;
      else if (wr_clr && link.wdata[SCU_FE])
        fef_q <= 1'b0;
      if (rx_done && rx_perr_q)
        pef_q <= 1'b1;
      else if (wr_clr && link.wdata[SCU_PE])
        pef_q <= 1'b0;
      if ((wr_data && se_q && bff_q) || rx_ovr)
        ovf_q <= 1'b1;
      else if (wr_clr && link.wdata[SCU_OV])
        ovf_q <= 1'b0;
    end
  end
  // link reads
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= link.req;
      rdata_q <= 16'h0000;
      if (link.req && !link.wr)
        unique case (link.addr)
          SCU_ADDR_COMM: rdata_q <= comm_q;
          SCU_ADDR_MODE: rdata_q <= mode_q;
          SCU_ADDR_DATA: rdata_q <= se_q ? {7'h00, data_q[8:0]} : data_q;
          SCU_ADDR_STATUS: rdata_q <= 16'({se_q, tx_q != SCU_IDLE, bff_q, 2'b00, fef_q, pef_q, ovf_q});
          default: rdata_q <= 16'h0000;
        endcase
    end
  end
  // transmitter; CSI frames carry no start bit
  assign tx_end = bit_tick & (((tx_q == SCU_STOP) && ({2'b00, stop_idx_q} + 4'd1 == {2'b00, nstop}))
    || ((tx_q == SCU_PAR) && (nstop == 2'd0))
    || ((tx_q == SCU_DATA) && (tx_idx_q == nbits - 4'd1) && (md != SCU_MODE_UART || (ptc == 2'b00 && nstop == 2'd0))));
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_q <= SCU_IDLE;
      tx_sh_q <= 9'h000;
      tx_idx_q <= 4'h0;
      stop_idx_q <= 2'd0;
    end
    else if (!se_q || tx_end)
      tx_q <= SCU_IDLE;
    else if (tx_load)
    begin
      tx_sh_q <= data_q[8:0] & dmask;
      tx_idx_q <= 4'h0;
      stop_idx_q <= 2'd0;
      tx_q <= (md == SCU_MODE_UART) ? SCU_START : SCU_DATA;
    end
    else if (bit_tick)
      unique case (tx_q)
        SCU_START: tx_q <= SCU_DATA;
        SCU_DATA:
        begin
          tx_idx_q <= tx_idx_q + 4'h1;
          if (tx_idx_q == nbits - 4'd1)
            tx_q <= (ptc != 2'b00) ? SCU_PAR : SCU_STOP;
        end
        SCU_PAR: tx_q <= SCU_STOP;
        SCU_STOP: stop_idx_q <= stop_idx_q + 2'd1;
        default: tx_q <= SCU_IDLE;
      endcase
  end
  // line outputs and interrupt pulses
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      txd_q <= 1'b1;
      sck_q <= 1'b1;
      chan_irq_q <= 1'b0;
    end
    else
    begin
      unique case (tx_q)
        SCU_START: txd_q <= 1'b0;
        SCU_DATA: txd_q <= tx_sh_q[dir ? tx_idx_q : nbits - 4'd1 - tx_idx_q];
        SCU_PAR: txd_q <= (ptc == 2'b01) ? 1'b0 : ((ptc == 2'b11) ^ (^tx_sh_q));
        default: txd_q <= 1'b1;
      endcase
      sck_q <= (tx_q != SCU_IDLE && md == SCU_MODE_CSI && !ccs) ? phase_q : 1'b1;
      chan_irq_q <= md_irq ? tx_load : tx_end;
    end
  end
  // receiver, sampled mid-bit from a falling start edge
  assign rx_done = (rx_q == SCU_STOP) && (rx_cnt_q == 8'h00);
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_q <= SCU_IDLE;
      rx_cnt_q <= 8'h00;
      rx_sh_q <= 9'h000;
      rx_idx_q <= 4'h0;
      rx_perr_q <= 1'b0;
      rxd_prev_q <= 1'b1;
    end
    else
    begin
      rxd_prev_q <= rxd;
      if (!(se_q && rxe && md == SCU_MODE_UART))
        rx_q <= SCU_IDLE;
      else if (rx_q == SCU_IDLE)
      begin
        if (rxd_prev_q && !rxd)
        begin
          rx_q <= SCU_START;
          rx_cnt_q <= {1'b0, div};
          rx_idx_q <= 4'h0;
          rx_sh_q <= 9'h000;
          rx_perr_q <= 1'b0;
        end
      end
      else if (rx_cnt_q != 8'h00)
        rx_cnt_q <= rx_cnt_q - 8'h01;
      else
      begin
        rx_cnt_q <= {div, 1'b1};
        unique case (rx_q)
          SCU_START: rx_q <= rxd ? SCU_IDLE : SCU_DATA;
          SCU_DATA:
          begin
            rx_sh_q[dir ? rx_idx_q : nbits - 4'd1 - rx_idx_q] <= rxd;
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == nbits - 4'd1)
              rx_q <= (ptc != 2'b00) ? SCU_PAR : SCU_STOP;
          end
          SCU_PAR: rx_perr_q <= ptc[1] & (rxd != ((ptc == 2'b11) ^ (^(rx_sh_q & dmask))));
          SCU_STOP: rx_q <= SCU_IDLE;
          default: rx_q <= SCU_IDLE;
        endcase
        if (rx_q == SCU_PAR)
          rx_q <= SCU_STOP;
      end
    end
  end
  // receive and error interrupts
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rcv_irq_q <= 1'b0;
      err_irq_q <= 1'b0;
    end
    else
    begin
      err_irq_q <= rx_done & eoc & (rx_fe | rx_perr_q | rx_ovr);
      rcv_irq_q <= rx_done & ~(eoc & (rx_fe | rx_perr_q | rx_ovr));
    end
  end
  assign link.rdata = rdata_q;
  assign link.ack = ack_q;
  assign link.chan_enabled = se_q;
  assign txd = txd_q;
  assign sck_out = sck_q;
  assign chan_irq = chan_irq_q;
  assign receive_interrupt = rcv_irq_q;
  assign error_interrupt = err_irq_q;
endmodule // scu_dev

/* File: core/scu_ctl.sv */
`timescale 1ns/1ps
module scu_ctl
  import scu_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // channel link
  scu_link_if.ctl link
);
  logic [7:0] awaddr_q;
  logic [31:0] wdata_hold_q;
  logic aw_q, w_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [24:0] cmd_q;
  logic [15:0] wd_q, rd_q, eff;
  logic busy_q, done_q, refused_q, req_q, wr_q;
  logic [1:0] md_q;
  logic do_wr, go, go_wr, refuse, hit;
  assign do_wr = aw_q & w_q & ~bvalid_q;
  assign go = do_wr & (awaddr_q == SCU_AXI_GO) & ~busy_q & (wdata_hold_q[1:0] != 2'b00);
  assign go_wr = wdata_hold_q[0];
  // mapped controller write addresses
  assign hit = (awaddr_q == SCU_AXI_ADDR) || (awaddr_q == SCU_AXI_WDATA) || (awaddr_q == SCU_AXI_GO)
    || (awaddr_q == SCU_AXI_STAT);
  // settings forced per mode before they reach the channel
  always_comb
  begin
    eff = wd_q;
    refuse = 1'b0;
    if (cmd_q[19:0] == SCU_ADDR_COMM)
    begin
      eff[SCU_ONE2] = 1'b1;
      eff[SCU_RSV3] = 1'b0;
      eff[SCU_RSV6] = 1'b0;
      eff[SCU_RSV11] = 1'b0;
      if (md_q == SCU_MODE_CSI)
      begin
        eff[SCU_SLC_LO+1:SCU_SLC_LO] = 2'b00;
        eff[SCU_PTC_LO+1:SCU_PTC_LO] = 2'b00;
        eff[SCU_EOC] = 1'b0;
      end
      else if (md_q == SCU_MODE_SIMPLE)
      begin
        eff[SCU_DIR] = 1'b0;
        eff[SCU_PTC_LO+1:SCU_PTC_LO] = 2'b00;
        eff[SCU_SLC_LO+1:SCU_SLC_LO] = 2'b01;
        eff[SCU_DLS_HI:SCU_DLS_LO] = 2'b11;
      end
      else if (eff[SCU_RXE])
        eff[SCU_SLC_LO+1:SCU_SLC_LO] = 2'b01;
      refuse = link.chan_enabled;
    end
    if (cmd_q[19:0] == SCU_ADDR_DATA && !link.chan_enabled && !cmd_q[SCU_CMD_BYTE])
      refuse = ((md_q == SCU_MODE_UART) && (wd_q[15:10] == 6'h00))
        || ((md_q == SCU_MODE_SIMPLE) && (wd_q[15:9] == 7'h00));
  end
  // axi write channel
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_hold_q <= 32'h0000_0000;
      bvalid_q <= 1'b0;
      bresp_q <= SCU_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_q && !bvalid_q)
      begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q && !bvalid_q)
      begin
        w_q <= 1'b1;
        wdata_hold_q <= s_axi_wdata;
      end
      if (do_wr)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= hit ? SCU_RESP_OKAY : SCU_RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end
  // command registers and link sequencing
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_q <= 25'h000_0000;
      wd_q <= 16'h0000;
      rd_q <= 16'h0000;
      md_q <= 2'b00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
      req_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else
    begin
      req_q <= 1'b0;
      if (do_wr && awaddr_q == SCU_AXI_ADDR && !busy_q && s_axi_wstrb != 4'h0)
        cmd_q <= wdata_hold_q[24:0];
      if (do_wr && awaddr_q == SCU_AXI_WDATA && !busy_q)
        wd_q <= wdata_hold_q[15:0];
      if (go && go_wr && refuse)
        refused_q <= 1'b1;
      else if (do_wr && awaddr_q == SCU_AXI_STAT && wdata_hold_q[2])
        refused_q <= 1'b0;
      if (go && !(go_wr && refuse))
      begin
        busy_q <= 1'b1;
        req_q <= 1'b1;
        wr_q <= go_wr;
        if (go_wr && cmd_q[19:0] == SCU_ADDR_MODE)
          md_q <= wd_q[SCU_MD_LO+1:SCU_MD_LO];
      end
      if (busy_q && link.ack)
      begin
        busy_q <= 1'b0;
        rd_q <= link.rdata;
      end
      if ((busy_q && link.ack) || (go && go_wr && refuse))
        done_q <= 1'b1;
      else if (do_wr && awaddr_q == SCU_AXI_STAT && wdata_hold_q[1])
        done_q <= 1'b0;
    end
  end
  // axi read channel
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= SCU_RESP_OKAY;
    end
    else
    begin
      arready_q <= s_axi_arvalid & ~arready_q & ~rvalid_q;
      if (arready_q)
      begin
        rvalid_q <= 1'b1;
        rresp_q <= SCU_RESP_OKAY;
        unique case (s_axi_araddr)
          SCU_AXI_ADDR: rdata_q <= {7'h00, cmd_q};
          SCU_AXI_WDATA: rdata_q <= {16'h0000, wd_q};
          SCU_AXI_GO: rdata_q <= 32'h0000_0000;
          SCU_AXI_RDATA: rdata_q <= {16'h0000, rd_q};
          SCU_AXI_STAT: rdata_q <= {28'h000_0000, link.chan_enabled, refused_q, done_q, busy_q};
          default:
          begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= SCU_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end
  assign s_axi_awready = ~aw_q & ~bvalid_q;
  assign s_axi_wready = ~w_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign link.req = req_q;
  assign link.wr = wr_q;
  assign link.byte_wr = cmd_q[SCU_CMD_BYTE];
  assign link.addr = cmd_q[19:0];
  assign link.wdata = eff;
endmodule // scu_ctl

/* File: tb/scu_link_properties.sv */
`timescale 1ns/1ps
module scu_link_properties
  import scu_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // link signals
  input wire logic req,
  input wire logic wr,
  input wire logic byte_wr,
  input wire logic [19:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic ack,
  input wire logic chan_enabled
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // request and answer pairing
  ack_after_req_a: assert property (req |=> ack && !req)
    else $error("ack missing after req");
  ack_needs_req_a: assert property (ack |-> $past(req))
    else $error("ack without req");
  // read values of trigger and data registers
  clear_reads_zero_a: assert property (ack && !$past(wr) && $past(addr) == SCU_ADDR_FLAG_CLR |-> rdata == 16'h0000)
    else $error("flag clear read not zero");
  divider_hidden_a: assert property (ack && !$past(wr) && $past(addr) == SCU_ADDR_DATA && $past(chan_enabled)
    |-> rdata[15:9] == 7'h00)
    else $error("divider visible while enabled");
  // setting register writes
  comm_locked_a: assert property (req && wr && addr == SCU_ADDR_COMM |-> !chan_enabled)
    else $error("comm write while enabled");
  reserved_fixed_a: assert property (req && wr && addr == SCU_ADDR_COMM
    |-> !wdata[11] && !wdata[6] && !wdata[3] && wdata[2])
    else $error("reserved comm bits wrong");
  // start and stop triggers
  start_enables_a: assert property (req && wr && addr == SCU_ADDR_START && wdata[0] |-> ##[1:3] chan_enabled)
    else $error("start did not enable");
  stop_disables_a: assert property (req && wr && addr == SCU_ADDR_STOP && wdata[0] |-> ##[1:3] !chan_enabled)
    else $error("stop did not disable");
endmodule // scu_link_properties

/* File: tb/serial_channel_frame_config_test.sv */
`timescale 1ns/1ps
module serial_channel_frame_config_test
  import scu_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic rxd = 1'b1;
  logic serial_clock_pin = 1'b1;
  logic txd;
  logic chan_irq;
  logic receive_interrupt;
  logic error_interrupt;
  logic [10:0] rx_frame;
  int n_irq = 0;
  int n_rirq = 0;
  int n_eirq = 0;
  int irq_early = 0;
  int irq_base = 0;
  int rirq_base = 0;
  int eirq_base = 0;
  logic [10:0] frame;
  logic got_frame = 1'b0;
  logic [31:0] s;
  logic [15:0] rd;
  logic [1:0] resp;
  logic refused;
  logic [31:0] seed = 32'h0001_094c;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  // both ends joined by the link
  scu_link_if link (.sys_clk, .rst);
  scu_ctl i_scu_ctl (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link(link));
  scu_dev i_scu_dev (.sys_clk, .rst, .link(link), .rxd, .serial_clock_pin, .txd, .sck_out(), .chan_irq,
    .receive_interrupt, .error_interrupt);
  scu_link_properties i_scu_link_properties (.sys_clk, .rst, .req(link.req), .wr(link.wr), .byte_wr(link.byte_wr),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .chan_enabled(link.chan_enabled));
  // 40 mhz clock
  always #12.5 sys_clk = ~sys_clk;
  // hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_errors++;
      conclude();
    end
  end
  // interrupt pulse counters
  always @(negedge sys_clk)
  begin
    if (chan_irq === 1'b1) n_irq++;
    if (receive_interrupt === 1'b1) n_rirq++;
    if (error_interrupt === 1'b1) n_eirq++;
  end
  // frame sampler, six-cycle bit time, mid-bit samples
  always
  begin
    @(negedge sys_clk);
    if (txd === 1'b0)
    begin
      irq_early = n_irq;
      repeat (3) @(negedge sys_clk);
      for (int i = 0; i < 11; i++)
      begin
        frame[i] = txd;
        repeat (6) @(negedge sys_clk);
      end
      got_frame = 1'b1;
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // start, data in line order, parity or idle, stop
  function automatic logic [10:0] exp_frame(input logic [7:0] d, input logic [1:0] ptc, input logic lsb);
    logic [7:0] o;
    logic p;
    o = lsb ? d : {<<{d}};
    p = (ptc == 2'b10) ? ^d : (ptc == 2'b11) ? ~^d : 1'b0;
    exp_frame = {1'b1, (ptc == 2'b00) ? 1'b1 : p, o, 1'b0};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      n_errors++;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  // one device access through the controller registers
  task automatic dev(input logic [19:0] a, input logic [15:0] d, input logic bw, input logic [1:0] go);
    logic [31:0] st;
    axi_wr(SCU_AXI_ADDR, {7'h00, bw, 4'h0, a});
    axi_wr(SCU_AXI_WDATA, {16'h0000, d});
    axi_wr(SCU_AXI_GO, {30'h0000_0000, go});
    do axi_rd(SCU_AXI_STAT, st); while (!st[1]);
    refused = st[2];
    axi_wr(SCU_AXI_STAT, 32'h0000_0006);
    axi_rd(SCU_AXI_RDATA, st);
    rd = st[15:0];
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    // reset values
    dev(SCU_ADDR_COMM, 16'h0000, 1'b0, 2'b10);
    check(rd, SCU_COMM_RST);
    dev(SCU_ADDR_DATA, 16'h0000, 1'b0, 2'b10);
    check(rd, SCU_DATA_RST);
    dev(SCU_ADDR_FLAG_CLR, 16'h0007, 1'b0, 2'b01);
    dev(SCU_ADDR_FLAG_CLR, 16'h0000, 1'b0, 2'b10);
    check(rd, 16'h0000);
    axi_wr(8'h20, 32'h0000_0001);
    check(resp, SCU_RESP_SLVERR);
    $display("reset test done");
    // divider access while stopped, then byte write
    seed = lfsr(seed);
    dev(SCU_ADDR_DATA, seed[15:0], 1'b0, 2'b01);
    dev(SCU_ADDR_DATA, 16'h0000, 1'b0, 2'b10);
    check(rd, seed[15:0]);
    dev(SCU_ADDR_DATA, 16'h00a5, 1'b1, 2'b01);
    dev(SCU_ADDR_DATA, 16'h0000, 1'b0, 2'b10);
    check({rd[15:9], rd[7:0]}, {7'h00, 8'ha5});
    dev(SCU_ADDR_MODE, 16'h0022, 1'b0, 2'b01);
    dev(SCU_ADDR_DATA, 16'h0400, 1'b0, 2'b01);
    $display("divider test done");
    // every parity code in both bit orders
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      dev(SCU_ADDR_STOP, 16'h0001, 1'b0, 2'b01);
      dev(SCU_ADDR_MODE, {15'h0011, k[0]}, 1'b0, 2'b01);
      dev(SCU_ADDR_COMM, {6'h20, k[1:0], k[2], 7'h17}, 1'b0, 2'b01);
      check(refused, 1'b0);
      dev(SCU_ADDR_START, 16'h0001, 1'b0, 2'b01);
      axi_rd(SCU_AXI_STAT, s);
      check(s[3], 1'b1);
      dev(SCU_ADDR_DATA, 16'h0000, 1'b0, 2'b10);
      check(rd[15:9], 7'h00);
      dev(SCU_ADDR_COMM, 16'h0087, 1'b0, 2'b01);
      check(refused, 1'b1);
      got_frame = 1'b0;
      irq_base = n_irq;
      dev(SCU_ADDR_DATA, {8'hfe, seed[7:0]}, 1'b0, 2'b01);
      wait (got_frame);
      check(frame, exp_frame(seed[7:0], k[1:0], k[2]));
      check(irq_early - irq_base, k[0]);
      check(n_irq - irq_base, 1);
      $display("frame test %0d done", k);
    end
    // reception, error mask set: bad parity, then good
    dev(SCU_ADDR_STOP, 16'h0001, 1'b0, 2'b01);
    dev(SCU_ADDR_COMM, 16'h4697, 1'b0, 2'b01);
    dev(SCU_ADDR_START, 16'h0001, 1'b0, 2'b01);
    for (int j = 0; j < 2; j++)
    begin
      seed = lfsr(seed);
      eirq_base = n_eirq;
      rirq_base = n_rirq;
      rx_frame = exp_frame(seed[7:0], 2'b10, 1'b1) ^ {1'b0, j == 0, 9'h000};
      for (int i = 0; i < 11; i++)
      begin
        rxd <= rx_frame[i];
        repeat (6) @(posedge sys_clk);
      end
      check(n_eirq - eirq_base, j == 0);
      check(n_rirq - rirq_base, j == 1);
      dev(SCU_ADDR_DATA, 16'h0000, 1'b0, 2'b10);
      check(rd, {8'h00, seed[7:0]});
    end
    dev(SCU_ADDR_STATUS, 16'h0000, 1'b0, 2'b10);
    check(rd[2:0], 3'b010);
    dev(SCU_ADDR_FLAG_CLR, 16'h0007, 1'b0, 2'b01);
    dev(SCU_ADDR_STATUS, 16'h0000, 1'b0, 2'b10);
    check(rd[2:0], 3'b000);
    $display("receive test done");
    // controller forcing per mode, divider floor
    dev(SCU_ADDR_STOP, 16'h0001, 1'b0, 2'b01);
    dev(SCU_ADDR_DATA, 16'h0200, 1'b0, 2'b01);
    check(refused, 1'b1);
    dev(SCU_ADDR_MODE, 16'h0024, 1'b0, 2'b01);
    dev(SCU_ADDR_COMM, 16'hcbf8, 1'b0, 2'b01);
    dev(SCU_ADDR_COMM, 16'h0000, 1'b0, 2'b10);
    check(rd, 16'hc017);
    dev(SCU_ADDR_MODE, 16'h0020, 1'b0, 2'b01);
    dev(SCU_ADDR_COMM, 16'hc7b8, 1'b0, 2'b01);
    dev(SCU_ADDR_COMM, 16'h0000, 1'b0, 2'b10);
    check(rd, 16'hc084);
    $display("forcing test done");
    conclude();
  end
endmodule // serial_channel_frame_config_test
